// File: verilog/afws_status_bank.sv
// fault and warning status bank of a four-channel amplifier with two alert outputs
// assumes detectors and the register port run on clk; ch1 is the msb of each channel vector
//
// Contract
// - per-channel overcurrent flags sit in channel fault bits 7..4, ch1 highest
// - per-channel dc-offset flags sit in channel fault bits 3..0, ch1 highest
// - invalid input clock shows in global fault one bit 4, else zero
// - power-stage overvoltage bit 3, battery overvoltage bit 2, while detected
// - power-stage undervoltage bit 1, battery undervoltage bit 0, while detected
// - global thermal shutdown shows in global fault two bit 4 at 0x12
// - per-channel thermal shutdown in global fault two bits 3..0, ch1 highest
// - warning register bit 5 reports that a power-on reset occurred
// - warning register bit 4 set while global thermal warning is present
// - per-channel thermal warnings in warning bits 3..0, ch1 highest
// - warning register reads 0x20 right after reset
// - mask bit 7 keeps overcurrent faults off the fault alert
// - mask bit 6 keeps thermal shutdown faults off the fault alert
// - mask bit 5 keeps undervoltage faults off the fault alert
// - mask bit 4 keeps overvoltage faults off the fault alert
// - mask bit 3 keeps dc-offset faults off the fault alert
// - mask bit 2 keeps current-limit events off the fault alert
// - mask bit 1 keeps clipping off the caution alert
// - mask bit 0 keeps thermal warnings off the caution alert
// - alert mask register resets to 0x00, reporting every class
// - channel fault register sits at offset 0x10
`include "afws_defs.svh"

module afws_status_bank (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire afws_pkg::afws_byte_t reg_wdata,
    output afws_pkg::afws_byte_t     reg_rdata,
    output logic                     reg_rvalid,
    input  wire afws_pkg::afws_chan_t overcurrent_in,
    input  wire afws_pkg::afws_chan_t dc_offset_in,
    input  wire logic                invalid_clock_in,
    input  wire logic                power_stage_overvoltage_flag,
    input  wire logic                battery_overvoltage_flag,
    input  wire logic                power_stage_undervoltage_flag,
    input  wire logic                battery_undervoltage_flag,
    input  wire logic                global_thermal_shutdown_flag,
    input  wire afws_pkg::afws_chan_t chan_thermal_shutdown_in,
    input  wire logic                global_thermal_warning_flag,
    input  wire afws_pkg::afws_chan_t chan_thermal_warning_in,
    input  wire logic                current_limit_in,
    input  wire logic                clipping_in,
    output logic                     fault_alert,
    output logic                     caution_alert
);
    import afws_pkg::*;

    // reset release through two flops
    logic        rst_meta_n;
    logic        rst_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    function automatic logic class_hit(input logic [7:0] flags, input logic suppress);
        class_hit = (|flags) && !suppress;
    endfunction

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] offs);
        addr_is = (a == offs);
    endfunction

    afws_byte_t  channel_fault_status;
    afws_byte_t  global_fault_status_one;
    afws_byte_t  global_fault_status_two;
    afws_byte_t  warning_status;
    afws_byte_t  alert_output_mask;
    logic        limit_q;
    logic        clip_q;

    afws_byte_t  next_channel_fault_status;
    afws_byte_t  next_global_fault_status_one;
    afws_byte_t  next_global_fault_status_two;
    afws_byte_t  next_warning_status;
    afws_byte_t  next_alert_output_mask;
    logic        next_limit_q;
    logic        next_clip_q;
    afws_byte_t  next_reg_rdata;
    logic        next_reg_rvalid;
    logic        next_fault_alert;
    logic        next_caution_alert;

    logic        suppress_overcurrent_alert;
    logic        suppress_thermal_shutdown_alert;
    logic        suppress_undervoltage_alert;
    logic        suppress_overvoltage_alert;
    logic        suppress_dc_offset_alert;
    logic        suppress_current_limit_alert;
    logic        suppress_clipping_alert;
    logic        suppress_thermal_warning_alert;

    assign suppress_overcurrent_alert      = alert_output_mask[`AFWS_SUP_OVERCURRENT];
    assign suppress_thermal_shutdown_alert = alert_output_mask[`AFWS_SUP_SHUTDOWN];
    assign suppress_undervoltage_alert     = alert_output_mask[`AFWS_SUP_UNDERVOLT];
    assign suppress_overvoltage_alert      = alert_output_mask[`AFWS_SUP_OVERVOLT];
    assign suppress_dc_offset_alert        = alert_output_mask[`AFWS_SUP_DC_OFFSET];
    assign suppress_current_limit_alert    = alert_output_mask[`AFWS_SUP_CURRENT_LIMIT];
    assign suppress_clipping_alert         = alert_output_mask[`AFWS_SUP_CLIPPING];
    assign suppress_thermal_warning_alert  = alert_output_mask[`AFWS_SUP_THERMAL_WARN];

    always_comb begin
        // live detector levels, sampled every cycle
        next_channel_fault_status    = {overcurrent_in, dc_offset_in};
        next_global_fault_status_one = 8'h00;
        next_global_fault_status_one[`AFWS_BIT_CLOCK_FAULT] = invalid_clock_in;
        next_global_fault_status_one[`AFWS_BIT_STAGE_HI] = power_stage_overvoltage_flag;
        next_global_fault_status_one[`AFWS_BIT_BATT_HI] = battery_overvoltage_flag;
        next_global_fault_status_one[`AFWS_BIT_STAGE_LO] = power_stage_undervoltage_flag;
        next_global_fault_status_one[`AFWS_BIT_BATT_LO] = battery_undervoltage_flag;
        next_global_fault_status_two = {3'h0, global_thermal_shutdown_flag,
                                        chan_thermal_shutdown_in};
        // power-on flag stays until the host reads the warning register
        next_warning_status = {2'h0, warning_status[`AFWS_BIT_POWER_ON],
                               global_thermal_warning_flag,
                               chan_thermal_warning_in};
        if (reg_rd && addr_is(reg_addr, `AFWS_ADDR_WARNING)) begin
            next_warning_status[`AFWS_BIT_POWER_ON] = 1'b0;
        end
        next_alert_output_mask = alert_output_mask;
        if (reg_wr && addr_is(reg_addr, `AFWS_ADDR_ALERT_MASK)) begin
            next_alert_output_mask = reg_wdata;
        end
        next_limit_q = current_limit_in;
        next_clip_q  = clipping_in;

        next_reg_rvalid = reg_rd;
        next_reg_rdata  = reg_rdata;
        if (reg_rd) begin
            unique case (reg_addr)
                `AFWS_ADDR_CHAN_FAULT: next_reg_rdata = channel_fault_status;
                `AFWS_ADDR_GLOBAL_ONE: next_reg_rdata = global_fault_status_one;
                `AFWS_ADDR_GLOBAL_TWO: next_reg_rdata = global_fault_status_two;
                `AFWS_ADDR_WARNING:    next_reg_rdata = warning_status;
                `AFWS_ADDR_ALERT_MASK: next_reg_rdata = alert_output_mask;
                default:               next_reg_rdata = `AFWS_RD_UNMAPPED;
            endcase
        end

        // clock fault has no mask and always reaches the fault alert
        next_fault_alert =
            class_hit({4'h0, channel_fault_status[7:4]}, suppress_overcurrent_alert) ||
            class_hit({3'h0, global_fault_status_two[4:0]},
                      suppress_thermal_shutdown_alert) ||
            class_hit({6'h0, global_fault_status_one[1:0]},
                      suppress_undervoltage_alert) ||
            class_hit({6'h0, global_fault_status_one[3:2]},
                      suppress_overvoltage_alert) ||
            class_hit({4'h0, channel_fault_status[3:0]}, suppress_dc_offset_alert) ||
            class_hit({7'h0, limit_q}, suppress_current_limit_alert) ||
            global_fault_status_one[`AFWS_BIT_CLOCK_FAULT];
        next_caution_alert =
            class_hit({7'h0, clip_q}, suppress_clipping_alert) ||
            class_hit({3'h0, warning_status[4:0]}, suppress_thermal_warning_alert);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_fault_status    <= `AFWS_RST_CHAN_FAULT;
            global_fault_status_one <= `AFWS_RST_GLOBAL_ONE;
            global_fault_status_two <= `AFWS_RST_GLOBAL_TWO;
            warning_status          <= `AFWS_RST_WARNING;
            alert_output_mask       <= `AFWS_RST_ALERT_MASK;
            limit_q                 <= 1'b0;
            clip_q                  <= 1'b0;
            reg_rdata               <= 8'h00;
            reg_rvalid              <= 1'b0;
            fault_alert             <= 1'b0;
            caution_alert           <= 1'b0;
        end else begin
            channel_fault_status    <= next_channel_fault_status;
            global_fault_status_one <= next_global_fault_status_one;
            global_fault_status_two <= next_global_fault_status_two;
            warning_status          <= next_warning_status;
            alert_output_mask       <= next_alert_output_mask;
            limit_q                 <= next_limit_q;
            clip_q                  <= next_clip_q;
            reg_rdata               <= next_reg_rdata;
            reg_rvalid              <= next_reg_rvalid;
            fault_alert             <= next_fault_alert;
            caution_alert           <= next_caution_alert;
        end
    end

    // checks
    sequence rd_of(logic [7:0] offs);
        reg_rd && (reg_addr == offs);
    endsequence

    sequence oc_unmasked;
        (|channel_fault_status[7:4]) && !alert_output_mask[`AFWS_SUP_OVERCURRENT];
    endsequence

    sequence all_quiet_faults;
        (alert_output_mask[7:2] == 6'h3f) && !global_fault_status_one[`AFWS_BIT_CLOCK_FAULT];
    endsequence

    oc_read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`AFWS_ADDR_CHAN_FAULT) |=> reg_rvalid && reg_rdata[7:4] == $past(overcurrent_in, 2))
        else $error("overcurrent flags read back wrong");

    dc_read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`AFWS_ADDR_CHAN_FAULT) |=> reg_rdata[3:0] == $past(dc_offset_in, 2))
        else $error("dc-offset flags read back wrong");

    clock_fault_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`AFWS_ADDR_GLOBAL_ONE) |=>
            reg_rdata[7:5] == 3'h0 && reg_rdata[4] == $past(invalid_clock_in, 2))
        else $error("clock fault bit read back wrong");

    supply_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 global_fault_status_one[3:2] ==
            $past({power_stage_overvoltage_flag, battery_overvoltage_flag}))
        else $error("overvoltage flags do not track detectors");

    undervolt_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`AFWS_ADDR_GLOBAL_ONE) |=> reg_rdata[1:0] ==
            $past({power_stage_undervoltage_flag, battery_undervoltage_flag}, 2))
        else $error("undervoltage flags read back wrong");

    thermal_sd_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`AFWS_ADDR_GLOBAL_TWO) |=> reg_rdata[7:5] == 3'h0 &&
            reg_rdata[4] == $past(global_thermal_shutdown_flag, 2))
        else $error("global shutdown bit read back wrong");

    chan_thermal_sd_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`AFWS_ADDR_GLOBAL_TWO) |=> reg_rdata[3:0] == $past(chan_thermal_shutdown_in, 2))
        else $error("channel shutdown bits read back wrong");

    por_after_reset_a: assert property (@(posedge clk)
        $rose(rst_n) |-> warning_status == `AFWS_RST_WARNING && alert_output_mask == 8'h00)
        else $error("reset values of warning or mask wrong");

    por_clear_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`AFWS_ADDR_WARNING) |=> !warning_status[`AFWS_BIT_POWER_ON])
        else $error("power-on flag not cleared by read");

    warn_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`AFWS_ADDR_WARNING) |=> reg_rdata[7:6] == 2'h0 &&
            reg_rdata[4:0] == $past({global_thermal_warning_flag, chan_thermal_warning_in}, 2))
        else $error("warning bits read back wrong");

    oc_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        oc_unmasked |=> fault_alert)
        else $error("unmasked overcurrent did not raise fault alert");

    faults_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
        all_quiet_faults |=> !fault_alert)
        else $error("fault alert raised with every class masked");

    caution_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 caution_alert == $past((clip_q && !alert_output_mask[`AFWS_SUP_CLIPPING]) ||
            ((|warning_status[4:0]) && !alert_output_mask[`AFWS_SUP_THERMAL_WARN])))
        else $error("caution alert does not follow unmasked warnings");

    mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == `AFWS_ADDR_ALERT_MASK ##1 !reg_wr ##1
            reg_rd && reg_addr == `AFWS_ADDR_ALERT_MASK && !reg_wr |=>
            reg_rdata == $past(reg_wdata, 3))
        else $error("mask register does not hold written value");

    ro_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == `AFWS_ADDR_CHAN_FAULT |=>
            channel_fault_status == $past({overcurrent_in, dc_offset_in}))
        else $error("write disturbed channel fault register");

    shutdown_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        (|global_fault_status_two[4:0]) && !alert_output_mask[`AFWS_SUP_SHUTDOWN]
            |=> fault_alert)
        else $error("unmasked thermal shutdown did not raise fault alert");

    undervolt_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        (|global_fault_status_one[1:0]) && !alert_output_mask[`AFWS_SUP_UNDERVOLT]
            |=> fault_alert)
        else $error("unmasked undervoltage did not raise fault alert");

    overvolt_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        (|global_fault_status_one[3:2]) && !alert_output_mask[`AFWS_SUP_OVERVOLT]
            |=> fault_alert)
        else $error("unmasked overvoltage did not raise fault alert");

    dc_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        (|channel_fault_status[3:0]) && !alert_output_mask[`AFWS_SUP_DC_OFFSET]
            |=> fault_alert)
        else $error("unmasked dc-offset did not raise fault alert");

    limit_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        limit_q && !alert_output_mask[`AFWS_SUP_CURRENT_LIMIT]
            |=> fault_alert)
        else $error("unmasked current limit did not raise fault alert");

    clip_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        clip_q && !alert_output_mask[`AFWS_SUP_CLIPPING]
            |=> caution_alert)
        else $error("unmasked clipping did not raise caution alert");

    warn_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        (|warning_status[4:0]) && !alert_output_mask[`AFWS_SUP_THERMAL_WARN]
            |=> caution_alert)
        else $error("unmasked thermal warning did not raise caution alert");

    caution_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (alert_output_mask[1:0] == 2'h3) |=> !caution_alert)
        else $error("caution alert raised with both classes masked");
endmodule

// File: shared/afws_defs.svh
// register offsets, field positions and reset values of the fault and warning bank
// assumes inclusion by bare name from the package and the design file
`ifndef AFWS_DEFS_SVH
`define AFWS_DEFS_SVH

`define AFWS_ADDR_CHAN_FAULT   8'h10
`define AFWS_ADDR_GLOBAL_ONE   8'h11
`define AFWS_ADDR_GLOBAL_TWO   8'h12
`define AFWS_ADDR_WARNING      8'h13
`define AFWS_ADDR_ALERT_MASK   8'h14

`define AFWS_RST_CHAN_FAULT    8'h00
`define AFWS_RST_GLOBAL_ONE    8'h00
`define AFWS_RST_GLOBAL_TWO    8'h00
`define AFWS_RST_WARNING       8'h20
`define AFWS_RST_ALERT_MASK    8'h00
`define AFWS_RD_UNMAPPED       8'h00

`define AFWS_BIT_CLOCK_FAULT   4
`define AFWS_BIT_STAGE_HI        3
`define AFWS_BIT_BATT_HI         2
`define AFWS_BIT_STAGE_LO        1
`define AFWS_BIT_BATT_LO         0
`define AFWS_BIT_GLOBAL_SHUTDOWN 4
`define AFWS_BIT_POWER_ON        5
`define AFWS_BIT_GLOBAL_WARN     4

`define AFWS_SUP_OVERCURRENT     7
`define AFWS_SUP_SHUTDOWN        6
`define AFWS_SUP_UNDERVOLT       5
`define AFWS_SUP_OVERVOLT        4
`define AFWS_SUP_DC_OFFSET       3
`define AFWS_SUP_CURRENT_LIMIT   2
`define AFWS_SUP_CLIPPING        1
`define AFWS_SUP_THERMAL_WARN    0

`endif

// File: shared/afws_pkg.sv
// types shared by the fault and warning status bank
// assumes afws_defs.svh on the include path
package afws_pkg;
    `include "afws_defs.svh"

    typedef logic [7:0] afws_byte_t;
    typedef logic [3:0] afws_chan_t;
endpackage

// File: testbench/afws_host_model.sv
// host side of the register port: single reads and writes
// assumes the bank takes a request on the rising clk edge and answers one edge later
module afws_host_model (
    input  wire logic                 clk,
    output logic [7:0]                reg_addr,
    output logic                      reg_wr,
    output logic                      reg_rd,
    output afws_pkg::afws_byte_t      reg_wdata,
    input  wire afws_pkg::afws_byte_t reg_rdata,
    input  wire logic                 reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    import afws_pkg::*;

    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // released lines show the inverse so stale values are never mistaken for live ones
    task automatic wr(input logic [7:0] a, input afws_byte_t d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output afws_byte_t d, output logic ok);
        int n;
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = 1'b0;
        d = 8'h00;
        for (n = 0; n < 4 && !ok; n++) begin
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                ok = 1'b1;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask
endmodule

// File: testbench/amp_fault_warning_status_bench.sv
// self-checking bench of the fault and warning status bank
// assumes the host model drives the register port and the bench drives every detector
module amp_fault_warning_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import afws_pkg::*;

    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] reg_addr;
    logic       reg_wr, reg_rd, reg_rvalid, fault_alert, caution_alert;
    afws_byte_t reg_wdata, reg_rdata;
    afws_chan_t oc = '0, dc = '0, cots = '0, cotw = '0;
    logic       inv = 0, pov = 0, bov = 0, puv = 0, buv = 0, gots = 0, gotw = 0;
    logic       ilim = 0, clip = 0;
    int         mismatches = 0;
    int         n_compared = 0;
    afws_byte_t alerts;

    assign alerts = {6'h00, fault_alert, caution_alert};

    always #5 clk = ~clk;

    afws_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    afws_status_bank u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .overcurrent_in(oc), .dc_offset_in(dc),
        .invalid_clock_in(inv), .power_stage_overvoltage_flag(pov),
        .battery_overvoltage_flag(bov), .power_stage_undervoltage_flag(puv),
        .battery_undervoltage_flag(buv), .global_thermal_shutdown_flag(gots),
        .chan_thermal_shutdown_in(cots), .global_thermal_warning_flag(gotw),
        .chan_thermal_warning_in(cotw), .current_limit_in(ilim), .clipping_in(clip),
        .fault_alert(fault_alert), .caution_alert(caution_alert));

    task automatic end_of_test();
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input afws_byte_t got, input afws_byte_t exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input afws_byte_t exp);
        afws_byte_t d;
        logic       ok;
        u_host.rd(a, d, ok);
        if (!ok) begin
            mismatches++;
            $display("mismatch at %0t: no read answer at %h", $time, a);
            end_of_test();
        end else begin
            check(d, exp, "read data");
        end
    endtask

    task automatic do_reset();
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // one alert class at a time: 0..5 fault classes, 6..7 caution classes
    task automatic set_src(input int i, input logic v);
        case (i)
            0: oc = {4{v}};
            1: gots = v;
            2: puv = v;
            3: bov = v;
            4: dc = {4{v}};
            5: ilim = v;
            6: clip = v;
            default: cotw = {4{v}};
        endcase
    endtask

    initial begin
        do_reset();
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h11, 8'h00);
        rd_chk(8'h12, 8'h00);
        rd_chk(8'h14, 8'h00);
        rd_chk(8'h13, 8'h20);
        rd_chk(8'h13, 8'h00);
        rd_chk(8'h15, 8'h00);
        for (int a = 16; a < 20; a++) u_host.wr(8'(a), 8'hff);
        for (int a = 16; a < 20; a++) rd_chk(8'(a), 8'h00);
        // two complementary detector patterns, ch1 in the top bit of each group
        for (int k = 0; k < 2; k++) begin
            {oc, dc, inv, pov, bov, puv, buv, gots, cots, gotw, cotw} =
                k ? ~23'h40d369 : 23'h40d369;
            rd_chk(8'h10, k ? 8'h7e : 8'h81);
            rd_chk(8'h11, k ? 8'h0b : 8'h14);
            rd_chk(8'h12, k ? 8'h04 : 8'h1b);
            rd_chk(8'h13, k ? 8'h16 : 8'h09);
        end
        {oc, dc, inv, pov, bov, puv, buv, gots, cots, gotw, cotw} = '0;
        for (int i = 0; i < 8; i++) begin
            u_host.wr(8'h14, 8'h00);
            set_src(i, 1'b1);
            repeat (3) @(posedge clk);
            #1;
            check(alerts, i < 6 ? 8'h02 : 8'h01, "alert");
            u_host.wr(8'h14, 8'h80 >> i);
            repeat (3) @(posedge clk);
            #1;
            check(alerts, 8'h00, "masked");
            set_src(i, 1'b0);
        end
        inv = 1'b1;
        u_host.wr(8'h14, 8'hff);
        repeat (3) @(posedge clk);
        #1;
        check(alerts, 8'h02, "clock fault");
        // every other source active with every class masked
        {oc, dc, inv, pov, bov, puv, buv, gots, cots, gotw, cotw} = ~23'h004000;
        {ilim, clip} = 2'h3;
        repeat (3) @(posedge clk);
        #1;
        check(alerts, 8'h00, "all masked");
        {oc, dc, inv, pov, bov, puv, buv, gots, cots, gotw, cotw} = 23'h000000;
        {ilim, clip} = 2'h0;
        u_host.wr(8'h14, 8'ha5);
        rd_chk(8'h14, 8'ha5);
        do_reset();
        rd_chk(8'h14, 8'h00);
        rd_chk(8'h13, 8'h20);
        end_of_test();
    end
endmodule
